// ===== sfp_defs.svh
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

// Device opcodes.
`define SFP_OP_QREAD 8'hEB
`define SFP_OP_PROG 8'h02
`define SFP_OP_QPROG_A 8'h32
`define SFP_OP_QPROG_B 8'h38
`define SFP_OP_SE_A 8'hD7
`define SFP_OP_SE_B 8'h20
`define SFP_OP_BE32 8'h52
`define SFP_OP_BE64 8'hD8
`define SFP_OP_CE_A 8'hC7
`define SFP_OP_CE_B 8'h60
`define SFP_OP_WRITE_ENABLE_CMD 8'h06
`define SFP_OP_WRDI 8'h04
`define SFP_OP_READ_STATUS_CMD 8'h05
`define SFP_OP_QPI_EN 8'h35
`define SFP_OP_QPI_EX 8'hF5

// Read timing and continuous read pattern.
`define SFP_CONT_PAT 4'hA
`define SFP_MODE_CYC 4'h2
`define SFP_DUMMY_RST 4'h6

// Array geometry; the modelled array aliases onto the low address bits.
`define SFP_MEM_AW 16
`define SFP_SECT_MASK 24'h000FFF
`define SFP_B32_MASK 24'h007FFF
`define SFP_B64_MASK 24'h00FFFF
`define SFP_PAGE_MASK 24'h0000FF
`define SFP_NUM_BLK 8'h80

// Link timing.
`define SFP_PCLK_NS 20
`define SFP_SCK_PERIOD_NS 160
`define SFP_SCK_DIV (`SFP_SCK_PERIOD_NS / `SFP_PCLK_NS)
`define SFP_CS_GAP 12'h004

// Controller register offsets.
`define SFP_REG_CMD 8'h00
`define SFP_REG_ADDR 8'h04
`define SFP_REG_MODE 8'h08
`define SFP_REG_WDATA 8'h0C
`define SFP_REG_RDATA 8'h10
`define SFP_REG_STAT 8'h14

// Command register fields.
`define SFP_C_SEND 8
`define SFP_C_QCMD 9
`define SFP_C_HADDR 10
`define SFP_C_QADDR 11
`define SFP_C_HMODE 12
`define SFP_C_RD 13
`define SFP_C_NB_LSB 16
`define SFP_C_DMY_LSB 20
`define SFP_C_GO 31

`endif

// ===== sfp_pkg.sv
package sfp_pkg;

  typedef enum logic [8:0] {
    D_CMD = 9'h001,
    D_ADDR = 9'h002,
    D_MODE = 9'h004,
    D_DMY = 9'h008,
    D_DOUT = 9'h010,
    D_STAT = 9'h020,
    D_PIN = 9'h040,
    D_HOLD = 9'h080,
    D_IGN = 9'h100
  } sfp_dev_st_e;

  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_OPC = 7'h02,
    H_ADDR = 7'h04,
    H_MODE = 7'h08,
    H_DMY = 7'h10,
    H_DATA = 7'h20,
    H_GAP = 7'h40
  } sfp_host_st_e;

endpackage

// ===== sfp_link_if.sv
interface sfp_link_if;
  logic sck;
  logic cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe_n;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe_n;
  logic [3:0] io;

  // Resolved data lines with a weak pull-up when nobody drives.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!h_io_oe_n[i])
        io[i] = h_io_o[i];
      else if (!d_io_oe_n[i])
        io[i] = d_io_o[i];
      else
        io[i] = 1'b1;
    end
  end

  modport host (output sck, output cs_n, output h_io_o, output h_io_oe_n,
                input io);
  modport dev (input sck, input cs_n, input io, output d_io_o,
               output d_io_oe_n);
endinterface

// ===== sfp_sync.sv
module sfp_sync #(
  parameter int W = 1
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ===== sfp_flash_dev.sv
// Functional notes
// - Four-wire mode takes quad read opcode in two clocks.
// - Mode nibble 1010 enables opcode-less continuous read.
// - Other mode nibble leaves continuous read.
// - Dummy count includes the two mode cycles.
// - Quad read while busy is ignored.
// - Reads leave command mode unchanged.
// - Host sends opcode, address, 1-256 bytes.
// - Programs into protected pages are dropped.
// - Program needs write enable latch set.
// - Program starts only on clean chip-select rise.
// - Busy flag high during program or erase.
// - Over 256 bytes wrap within the page.
// - Unsupplied page bytes keep their contents.
// - Programming only clears bits to zero.
// - Quad program needs quad enable and latch.
// - Sectors 4K, blocks of eight or sixteen.
// - Sector erase needs address and latch.
// - Block erase 32K or 64K needs latch.
// - Chip erase erases all, needs latch.
// - Erase completion clears write enable latch.
// - Host holds select low through erase command.
// - Write enable sets latch, clear at reset.
// - Read status returns busy flag.
`include "sfp_defs.svh"

module sfp_flash_dev
  import sfp_pkg::*;
(
  // System
  input wire logic pclk,
  input wire logic presetn,
  // Link
  sfp_link_if.dev link,
  // Configuration
  input wire logic [3:0] dummy_cfg,
  input wire logic [3:0] protect_level,
  input wire logic top_bottom_select,
  input wire logic quad_enable_bit,
  // Status
  output logic busy_flag,
  output logic write_enable_latch,
  output logic four_wire_command_mode,
  output logic continuous_read_mode
);
  localparam int MEM_N = 1 << `SFP_MEM_AW;

  logic [5:0] sync_q;
  logic cs_n_s;
  logic sck_s;
  logic [3:0] io_s;
  logic sck_d_r;
  logic cs_d_r;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  sfp_dev_st_e st_r;
  logic [7:0] cmd_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic [1:0] abyte_r;
  logic [23:0] addr_r;
  logic [3:0] dmy_r;
  logic wide_r;
  logic got_r;
  logic cont_r;
  logic qpi_r;
  logic [3:0] dio_r;
  logic [3:0] doe_n_r;
  logic busy_r;
  logic wel_r;
  logic prog_r;
  logic [23:0] cur_r;
  logic [23:0] last_r;
  logic [255:0] pvalid_r;
  logic [7:0] pbuf [0:255];
  logic [7:0] mem [0:MEM_N-1];
  logic [7:0] sh_nxt;
  logic [3:0] in_cnt_nxt;
  logic in_done;
  logic [3:0] ocnt_nxt;
  logic [7:0] stat_byte;
  logic [7:0] out_byte;
  logic is_erase;
  logic start_prog;
  logic start_erase;
  logic [23:0] emask;

  sfp_sync #(.W(6)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    // Select travels inverted so its reset value matches the idle level.
    .d({~link.cs_n, link.sck, link.io}),
    .q(sync_q)
  );

  assign cs_n_s = ~sync_q[5];
  assign sck_s = sync_q[4];
  assign io_s = sync_q[3:0];
  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;
  assign cs_rise = cs_n_s & ~cs_d_r;

  // Wide fields move a nibble per clock, narrow ones a bit on line 0.
  assign sh_nxt = wide_r ? {sh_r[3:0], io_s} : {sh_r[6:0], io_s[0]};
  assign in_cnt_nxt = cnt_r + (wide_r ? 4'h4 : 4'h1);
  assign in_done = in_cnt_nxt[3];
  assign ocnt_nxt = {1'b0, cnt_r[2:0]} + (wide_r ? 4'h4 : 4'h1);
  assign stat_byte = {1'b0, quad_enable_bit, protect_level, wel_r,
                      busy_r};
  assign out_byte = (st_r == D_STAT) ? stat_byte
                                      : mem[addr_r[`SFP_MEM_AW-1:0]];
  assign is_erase = (cmd_r == `SFP_OP_SE_A) || (cmd_r == `SFP_OP_SE_B) ||
                    (cmd_r == `SFP_OP_BE32) || (cmd_r == `SFP_OP_BE64) ||
                    (cmd_r == `SFP_OP_CE_A) || (cmd_r == `SFP_OP_CE_B);

  // Protected area: 2**(level-1) top or bottom 64K blocks, all 128 from level 8 up, level 0 none.
  function automatic logic prot_hit(input logic [23:0] a,
                                    input logic whole);
    logic [7:0] n;
    logic [7:0] blk;
    n = (protect_level >= 4'h8) ? `SFP_NUM_BLK
                                : (8'h01 << (protect_level - 4'h1));
    blk = {1'b0, a[22:16]};
    if (protect_level == 4'h0)
      prot_hit = 1'b0;
    else if (whole)
      prot_hit = 1'b1;
    else if (top_bottom_select)
      prot_hit = blk < n;
    else
      prot_hit = blk >= (`SFP_NUM_BLK - n);
  endfunction

  always_comb
  begin
    case (cmd_r)
      `SFP_OP_SE_A, `SFP_OP_SE_B: emask = `SFP_SECT_MASK;
      `SFP_OP_BE32: emask = `SFP_B32_MASK;
      `SFP_OP_BE64: emask = `SFP_B64_MASK;
      `SFP_OP_CE_A, `SFP_OP_CE_B: emask = 24'((MEM_N) - 1);
      default: emask = `SFP_PAGE_MASK;
    endcase
  end

  assign start_prog = cs_rise && (st_r == D_PIN) && got_r &&
                      (cnt_r == 4'h0) && !prot_hit(addr_r, 1'b0);
  assign start_erase = cs_rise && (st_r == D_HOLD) && is_erase &&
                       !prot_hit(addr_r, (cmd_r == `SFP_OP_CE_A) ||
                                         (cmd_r == `SFP_OP_CE_B));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      sck_d_r <= sck_s;
      cs_d_r <= cs_n_s;
    end
  end

  // Link command sequencer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= D_CMD;
      cmd_r <= 8'h00;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      abyte_r <= 2'h0;
      addr_r <= 24'h000000;
      dmy_r <= 4'h0;
      wide_r <= 1'b0;
      got_r <= 1'b0;
      cont_r <= 1'b0;
      qpi_r <= 1'b0;
      dio_r <= 4'h0;
      doe_n_r <= 4'hF;
      pvalid_r <= '0;
    end
    else if (cs_n_s)
    begin
      // Continuous read starts at the address; busy discards it.
      st_r <= cont_r ? (busy_r ? D_IGN : D_ADDR) : D_CMD;
      cmd_r <= cont_r ? `SFP_OP_QREAD : 8'h00;
      wide_r <= cont_r | qpi_r;
      cnt_r <= 4'h0;
      abyte_r <= 2'h0;
      got_r <= 1'b0;
      doe_n_r <= 4'hF;
      if (cs_rise && st_r == D_HOLD && cmd_r == `SFP_OP_QPI_EN)
        qpi_r <= 1'b1;
      else if (cs_rise && st_r == D_HOLD && cmd_r == `SFP_OP_QPI_EX)
        qpi_r <= 1'b0;
    end
    else if (sck_rise)
    begin
      case (st_r)
        D_CMD, D_ADDR, D_MODE, D_PIN:
        begin
          sh_r <= sh_nxt;
          cnt_r <= in_done ? 4'h0 : in_cnt_nxt;
          if (in_done && st_r == D_CMD)
          begin
            cmd_r <= sh_nxt;
            if (busy_r && sh_nxt != `SFP_OP_READ_STATUS_CMD)
              st_r <= D_IGN;
            else
            begin
              case (sh_nxt)
                `SFP_OP_QREAD:
                begin
                  wide_r <= 1'b1;
                  st_r <= D_ADDR;
                end
                `SFP_OP_PROG:
                begin
                  st_r <= wel_r ? D_ADDR : D_IGN;
                  pvalid_r <= '0;
                end
                `SFP_OP_QPROG_A, `SFP_OP_QPROG_B:
                begin
                  st_r <= (wel_r && quad_enable_bit) ? D_ADDR : D_IGN;
                  wide_r <= 1'b1;
                  pvalid_r <= '0;
                end
                `SFP_OP_SE_A, `SFP_OP_SE_B, `SFP_OP_BE32, `SFP_OP_BE64:
                  st_r <= wel_r ? D_ADDR : D_IGN;
                `SFP_OP_CE_A, `SFP_OP_CE_B:
                  st_r <= wel_r ? D_HOLD : D_IGN;
                `SFP_OP_WRITE_ENABLE_CMD, `SFP_OP_WRDI, `SFP_OP_QPI_EN, `SFP_OP_QPI_EX:
                  st_r <= D_HOLD;
                `SFP_OP_READ_STATUS_CMD:
                  st_r <= D_STAT;
                default:
                  st_r <= D_IGN;
              endcase
            end
          end
          else if (in_done && st_r == D_ADDR)
          begin
            addr_r <= {addr_r[15:0], sh_nxt};
            abyte_r <= abyte_r + 2'h1;
            if (abyte_r == 2'h2)
            begin
              if (cmd_r == `SFP_OP_QREAD)
                st_r <= D_MODE;
              else if (is_erase)
                st_r <= D_HOLD;
              else
                st_r <= D_PIN;
            end
          end
          else if (in_done && st_r == D_MODE)
          begin
            cont_r <= (sh_nxt[7:4] == `SFP_CONT_PAT);
            dmy_r <= dummy_cfg - `SFP_MODE_CYC;
            st_r <= (dummy_cfg > `SFP_MODE_CYC) ? D_DMY : D_DOUT;
          end
          else if (in_done && st_r == D_PIN)
          begin
            pvalid_r[addr_r[7:0]] <= 1'b1;
            addr_r[7:0] <= addr_r[7:0] + 8'h01;
            got_r <= 1'b1;
          end
        end
        D_DMY:
        begin
          dmy_r <= dmy_r - 4'h1;
          if (dmy_r == 4'h1)
            st_r <= D_DOUT;
        end
        D_DOUT, D_STAT:
        begin
          cnt_r <= {1'b0, ocnt_nxt[2:0]};
          if (ocnt_nxt[3] && st_r == D_DOUT)
            addr_r <= addr_r + 24'h000001;
        end
        D_HOLD:
          st_r <= D_IGN;
        default:
          st_r <= D_IGN;
      endcase
    end
    else if (sck_fall && (st_r == D_DOUT || st_r == D_STAT))
    begin
      // Reads never touch the command mode flag.
      if (wide_r)
      begin
        dio_r <= cnt_r[2] ? out_byte[3:0] : out_byte[7:4];
        doe_n_r <= 4'h0;
      end
      else
      begin
        dio_r <= {2'b00, out_byte[3'h7 - cnt_r[2:0]], 1'b0};
        doe_n_r <= 4'hD;
      end
    end
  end

  always_ff @(posedge pclk)
  begin
    if (!cs_n_s && sck_rise && st_r == D_PIN && in_done)
      pbuf[addr_r[7:0]] <= sh_nxt;
  end

  // Self-timed program and erase engine, one byte per clock.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_r <= 1'b0;
      wel_r <= 1'b0;
      prog_r <= 1'b0;
      cur_r <= 24'h000000;
      last_r <= 24'h000000;
    end
    else if (start_prog || start_erase)
    begin
      busy_r <= 1'b1;
      prog_r <= start_prog;
      cur_r <= addr_r & ~emask;
      last_r <= addr_r | emask;
    end
    else if (busy_r)
    begin
      if (cur_r == last_r)
      begin
        busy_r <= 1'b0;
        wel_r <= 1'b0;
      end
      else
        cur_r <= cur_r + 24'h000001;
    end
    else if (cs_rise && st_r == D_HOLD && cmd_r == `SFP_OP_WRITE_ENABLE_CMD)
      wel_r <= 1'b1;
    else if (cs_rise && st_r == D_HOLD && cmd_r == `SFP_OP_WRDI)
      wel_r <= 1'b0;
  end

  always_ff @(posedge pclk)
  begin
    if (busy_r)
    begin
      if (prog_r)
        mem[cur_r[`SFP_MEM_AW-1:0]] <= mem[cur_r[`SFP_MEM_AW-1:0]] &
          (pvalid_r[cur_r[7:0]] ? pbuf[cur_r[7:0]] : 8'hFF);
      else
        mem[cur_r[`SFP_MEM_AW-1:0]] <= 8'hFF;
    end
  end

  assign link.d_io_o = dio_r;
  assign link.d_io_oe_n = doe_n_r;
  assign busy_flag = busy_r;
  assign write_enable_latch = wel_r;
  assign four_wire_command_mode = qpi_r;
  assign continuous_read_mode = cont_r;
endmodule

// ===== sfp_flash_host.sv
`include "sfp_defs.svh"

module sfp_flash_host
  import sfp_pkg::*;
(
  // System
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  sfp_link_if.host link
);
  localparam logic [2:0] DIV_LAST = 3'(`SFP_SCK_DIV - 1);
  localparam logic [2:0] DIV_HALF = 3'(`SFP_SCK_DIV / 2);

  logic [3:0] io_s;
  sfp_host_st_e st_r;
  logic [31:0] ctl_r;
  logic [23:0] addr_r;
  logic [7:0] mode_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [2:0] div_r;
  logic [11:0] lft_r;
  logic [31:0] sh_r;
  logic [31:0] rx_r;
  logic sck_r;
  logic cs_n_r;
  logic [3:0] hio_r;
  logic [3:0] hoe_n_r;
  logic wide;
  logic rcv;
  logic wr_acc;
  logic go;

  sfp_sync #(.W(4)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.io),
    .q(io_s)
  );

  assign wide = (st_r == H_OPC) ? ctl_r[`SFP_C_QCMD] : ctl_r[`SFP_C_QADDR];
  assign rcv = (st_r == H_DMY) || (st_r == H_DATA && ctl_r[`SFP_C_RD]);
  assign wr_acc = psel && penable && pready_r && pwrite;
  assign go = wr_acc && paddr == `SFP_REG_CMD && pwdata[`SFP_C_GO] &&
              st_r == H_IDLE;

  // Register bus, one wait-free access phase per transfer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      ctl_r <= 32'h00000000;
      addr_r <= 24'h000000;
      mode_r <= 8'h00;
      wdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= psel && !penable;
      if (psel && !penable)
      begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
        if (paddr == `SFP_REG_CMD)
          prdata_r <= ctl_r;
        else if (paddr == `SFP_REG_ADDR)
          prdata_r <= {8'h00, addr_r};
        else if (paddr == `SFP_REG_MODE)
          prdata_r <= {24'h000000, mode_r};
        else if (paddr == `SFP_REG_WDATA)
          prdata_r <= wdata_r;
        else if (paddr == `SFP_REG_RDATA)
          prdata_r <= rdata_r;
        else if (paddr == `SFP_REG_STAT)
          prdata_r <= {31'h00000000, st_r != H_IDLE};
        else
          pslverr_r <= 1'b1;
      end
      if (wr_acc && st_r == H_IDLE)
      begin
        if (paddr == `SFP_REG_CMD)
          ctl_r <= {1'b0, pwdata[30:0]};
        else if (paddr == `SFP_REG_ADDR)
          addr_r <= pwdata[23:0];
        else if (paddr == `SFP_REG_MODE)
          mode_r <= pwdata[7:0];
        else if (paddr == `SFP_REG_WDATA)
          wdata_r <= pwdata;
      end
    end
  end

  // Link sequencer; the serial clock is pclk divided down.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= H_IDLE;
      div_r <= 3'h0;
      lft_r <= 12'h000;
      sh_r <= 32'h00000000;
      rx_r <= 32'h00000000;
      rdata_r <= 32'h00000000;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      hio_r <= 4'h0;
      hoe_n_r <= 4'hF;
    end
    else if (go)
    begin
      st_r <= H_OPC;
      cs_n_r <= 1'b0;
      div_r <= 3'h0;
      sh_r <= {pwdata[7:0], 24'h000000};
      lft_r <= !pwdata[`SFP_C_SEND] ? 12'h000 :
               (pwdata[`SFP_C_QCMD] ? 12'h002 : 12'h008);
    end
    else if (st_r != H_IDLE && div_r == 3'h0 && lft_r == 12'h000)
    begin
      sck_r <= 1'b0;
      hoe_n_r <= 4'hF;
      case (st_r)
        H_OPC:
        begin
          st_r <= H_ADDR;
          sh_r <= {addr_r, 8'h00};
          lft_r <= !ctl_r[`SFP_C_HADDR] ? 12'h000 :
                   (ctl_r[`SFP_C_QADDR] ? 12'h006 : 12'h018);
        end
        H_ADDR:
        begin
          st_r <= H_MODE;
          sh_r <= {mode_r, 24'h000000};
          lft_r <= !ctl_r[`SFP_C_HMODE] ? 12'h000 :
                   (ctl_r[`SFP_C_QADDR] ? 12'h002 : 12'h008);
        end
        H_MODE:
        begin
          st_r <= H_DMY;
          lft_r <= {8'h00, ctl_r[`SFP_C_DMY_LSB +: 4]};
        end
        H_DMY:
        begin
          st_r <= H_DATA;
          sh_r <= wdata_r;
          rx_r <= 32'h00000000;
          // Two clocks per byte on four lines, eight on one.
          lft_r <= ctl_r[`SFP_C_QADDR] ?
                   {8'h00, ctl_r[`SFP_C_NB_LSB +: 3], 1'b0} :
                   {6'h00, ctl_r[`SFP_C_NB_LSB +: 3], 3'b000};
        end
        H_DATA:
        begin
          // Chip select rises only after whole bytes.
          st_r <= H_GAP;
          cs_n_r <= 1'b1;
          lft_r <= `SFP_CS_GAP;
        end
        default:
        begin
          st_r <= H_IDLE;
          rdata_r <= rx_r;
        end
      endcase
    end
    else if (st_r != H_IDLE)
    begin
      div_r <= (div_r == DIV_LAST) ? 3'h0 : div_r + 3'h1;
      if (div_r == 3'h0 && st_r != H_GAP)
      begin
        sck_r <= 1'b0;
        if (rcv)
          hoe_n_r <= 4'hF;
        else
        begin
          hio_r <= wide ? sh_r[31:28] : {3'b000, sh_r[31]};
          hoe_n_r <= wide ? 4'h0 : 4'hE;
          sh_r <= wide ? {sh_r[27:0], 4'h0} : {sh_r[30:0], 1'b0};
        end
      end
      else if (div_r == DIV_HALF && st_r != H_GAP)
        sck_r <= 1'b1;
      else if (div_r == DIV_LAST)
      begin
        lft_r <= lft_r - 12'h001;
        if (st_r == H_DATA && ctl_r[`SFP_C_RD])
          rx_r <= wide ? {rx_r[27:0], io_s} : {rx_r[30:0], io_s[1]};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign link.sck = sck_r;
  assign link.cs_n = cs_n_r;
  assign link.h_io_o = hio_r;
  assign link.h_io_oe_n = hoe_n_r;
endmodule

// ===== sfp_link_props.sv
module sfp_link_props (
  // System
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] h_io_oe_n,
  input wire logic [3:0] d_io_oe_n,
  // Device status
  input wire logic busy_flag,
  input wire logic write_enable_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_no_fight:
    assert property ((h_io_oe_n | d_io_oe_n) == 4'hF)
    else $error("Both ends drive a data line.");
  chk_sck_idle:
    assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("Link clock moves while deselected.");
  chk_cs_gap:
    assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("Select gap too short.");
  chk_dev_release:
    assert property (cs_n [*6] |-> d_io_oe_n == 4'hF)
    else $error("Device drives while deselected.");
  chk_busy_on_cs:
    assert property ($rose(busy_flag) |-> cs_n && $past(cs_n))
    else $error("Busy rose while selected.");
  chk_busy_wel:
    assert property ($rose(busy_flag) |-> write_enable_latch)
    else $error("Busy rose without latch.");
  chk_busy_hold:
    assert property ($rose(busy_flag) |-> busy_flag [*8])
    else $error("Busy pulse too short.");
  chk_wel_clear:
    assert property ($fell(busy_flag) |-> ##[0:2] !write_enable_latch)
    else $error("Latch kept after operation.");
  chk_wel_set_idle:
    assert property ($rose(write_enable_latch) |-> cs_n)
    else $error("Latch set while selected.");
endmodule

// ===== test_serial_flash_program_erase.sv
`include "sfp_defs.svh"

module test_serial_flash_program_erase import sfp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] F_CMD = 6'h01;
  localparam logic [5:0] F_ADR = 6'h05;
  localparam logic [5:0] F_QRD = 6'h3D;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] dummy_cfg = 4'h6;
  logic [3:0] protect_level = 4'h0;
  logic top_bottom_select = 1'b0;
  logic quad_enable_bit = 1'b1;
  logic busy_flag;
  logic write_enable_latch;
  logic four_wire_command_mode;
  logic continuous_read_mode;
  logic [31:0] rd;
  logic slverr;
  logic [7:0] ers [4] = '{`SFP_OP_BE32, `SFP_OP_BE64, `SFP_OP_CE_A,
                          `SFP_OP_CE_B};
  int errors = 0;
  int checked = 0;
  int cyc = 0;

  sfp_link_if link();
  sfp_flash_host i_sfp_flash_host(.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  sfp_flash_dev i_sfp_flash_dev(.pclk(pclk), .presetn(presetn),
    .link(link), .dummy_cfg(dummy_cfg), .protect_level(protect_level),
    .top_bottom_select(top_bottom_select),
    .quad_enable_bit(quad_enable_bit), .busy_flag(busy_flag),
    .write_enable_latch(write_enable_latch),
    .four_wire_command_mode(four_wire_command_mode),
    .continuous_read_mode(continuous_read_mode));
  sfp_link_props i_props(.pclk(pclk), .presetn(presetn), .sck(link.sck),
    .cs_n(link.cs_n), .h_io_oe_n(link.h_io_oe_n),
    .d_io_oe_n(link.d_io_oe_n), .busy_flag(busy_flag),
    .write_enable_latch(write_enable_latch));

  always #10 pclk = ~pclk;

  task automatic end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run(input logic [7:0] o, input logic [5:0] f,
                     input logic [2:0] n, input logic [23:0] a,
                     input logic [7:0] m, input logic [31:0] d);
    apb(1'b1, `SFP_REG_ADDR, {8'h00, a});
    apb(1'b1, `SFP_REG_MODE, {24'h0, m});
    apb(1'b1, `SFP_REG_WDATA, d);
    apb(1'b1, `SFP_REG_CMD, {1'b1, 7'h0,
        (f[4] ? dummy_cfg - `SFP_MODE_CYC : 4'h0), 1'b0, n, 2'b00, f,
        o});
    rd = 32'h1;
    while (rd[0] !== 1'b0)
      apb(1'b0, `SFP_REG_STAT, 32'h0);
    apb(1'b0, `SFP_REG_RDATA, 32'h0);
  endtask

  task automatic stat(input logic [7:0] e);
    run(`SFP_OP_READ_STATUS_CMD, 6'h21, 3'd1, 24'h0, 8'h00, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, e});
  endtask

  task automatic wait_dev;
    rd = 32'h1;
    while (rd[0] !== 1'b0)
      run(`SFP_OP_READ_STATUS_CMD, 6'h21, 3'd1, 24'h0, 8'h00, 32'h0);
  endtask

  task automatic write_enable_cmd;
    run(`SFP_OP_WRITE_ENABLE_CMD, F_CMD, 3'd0, 24'h0, 8'h00, 32'h0);
  endtask

  task automatic prog(input logic [23:0] a, input logic [31:0] d);
    run(`SFP_OP_PROG, F_ADR, 3'd4, a, 8'h00, d);
  endtask

  task automatic rdq(input logic [23:0] a, input logic [7:0] m);
    run(`SFP_OP_QREAD, F_QRD, 3'd4, a, m, 32'h0);
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, slverr}, 32'h1);
    stat(8'h40);
    for (int i = 0; i < 4; i++)
    begin
      run(ers[i], (i < 2) ? F_ADR : F_CMD, 3'd0, 24'h0, 8'h00, 32'h0);
      chk({31'h0, busy_flag}, 32'h0);
    end
    write_enable_cmd();
    stat(8'h42);
    $display("status and latch done");
    run(`SFP_OP_SE_B, F_ADR, 3'd0, 24'h000ABC, 8'h00, 32'h0);
    chk({31'h0, busy_flag}, 32'h1);
    wait_dev();
    stat(8'h40);
    rdq(24'h0, 8'h00);
    chk(rd, 32'hFFFFFFFF);
    prog(24'h10, 32'h12345678);
    chk({31'h0, busy_flag}, 32'h0);
    write_enable_cmd();
    prog(24'h10, 32'h12345678);
    wait_dev();
    rdq(24'h0F, 8'h00);
    chk(rd, 32'hFF123456);
    write_enable_cmd();
    prog(24'h10, 32'h0F0F0F0F);
    wait_dev();
    rdq(24'h10, 8'hA5);
    chk(rd, 32'h02040608);
    chk({31'h0, continuous_read_mode}, 32'h1);
    run(`SFP_OP_QREAD, 6'h3C, 3'd4, 24'h11, 8'h00, 32'h0);
    chk(rd, 32'h040608FF);
    chk({31'h0, continuous_read_mode}, 32'h0);
    $display("program and read done");
    run(`SFP_OP_QPI_EN, F_CMD, 3'd0, 24'h0, 8'h00, 32'h0);
    chk({31'h0, four_wire_command_mode}, 32'h1);
    run(`SFP_OP_QREAD, 6'h3F, 3'd4, 24'h10, 8'h00, 32'h0);
    chk(rd, 32'h02040608);
    chk({31'h0, four_wire_command_mode}, 32'h1);
    run(`SFP_OP_QPI_EX, 6'h03, 3'd0, 24'h0, 8'h00, 32'h0);
    chk({31'h0, four_wire_command_mode}, 32'h0);
    $display("four-wire mode done");
    write_enable_cmd();
    protect_level <= 4'h8;
    prog(24'h30, 32'h0);
    stat(8'h62);
    protect_level <= 4'h0;
    quad_enable_bit <= 1'b0;
    run(`SFP_OP_QPROG_A, 6'h0D, 3'd4, 24'h30, 8'h00, 32'h0);
    stat(8'h02);
    quad_enable_bit <= 1'b1;
    rdq(24'h30, 8'h00);
    chk(rd, 32'hFFFFFFFF);
    run(`SFP_OP_SE_A, F_ADR, 3'd0, 24'h0, 8'h00, 32'h0);
    rdq(24'h10, 8'h00);
    stat(8'h43);
    wait_dev();
    rdq(24'h10, 8'h00);
    chk(rd, 32'hFFFFFFFF);
    write_enable_cmd();
    prog(24'hFE, 32'h11223344);
    wait_dev();
    rdq(24'hFE, 8'h00);
    chk(rd, 32'h1122FFFF);
    rdq(24'h00, 8'h00);
    chk(rd, 32'h3344FFFF);
    $display("refusals and erase done");
    end_sim();
  end
endmodule
